// ---- design/ddac_pkg.sv ----
// Package for the dual converter control registers.
// Assumes an 8-bit special-function-register bus with one clock.
package ddac_pkg;

    // ----------------------------------------
    // Register offsets on the register bus
    // ----------------------------------------
    localparam logic [7:0] DDAC_ADDR_C0_LOW = 8'hf9; // chan0_code_low
    localparam logic [7:0] DDAC_ADDR_C0_HIGH = 8'hfa; // chan0_code_high
    localparam logic [7:0] DDAC_ADDR_C1_LOW = 8'hfb; // chan1_code_low
    localparam logic [7:0] DDAC_ADDR_C1_HIGH = 8'hfc; // chan1_code_high
    localparam logic [7:0] DDAC_ADDR_CTRL = 8'hfd; // converter_control

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] DDAC_RST_CODE = 8'h00; // All four data registers
    localparam logic [7:0] DDAC_RST_CTRL = 8'h04; // Asynchronous update, all off

    // ----------------------------------------
    // Field positions in converter_control
    // ----------------------------------------
    localparam int DDAC_BIT_MODE8 = 7; // 1: 8-bit mode for both channels
    localparam int DDAC_BIT_SPAN1 = 6; // chan1_span_select
    localparam int DDAC_BIT_SPAN0 = 5; // chan0_span_select
    localparam int DDAC_BIT_ZFN1 = 4; // chan1_zero_force_n
    localparam int DDAC_BIT_ZFN0 = 3; // chan0_zero_force_n
    localparam int DDAC_BIT_ASYNC = 2; // 1: asynchronous update
    localparam int DDAC_BIT_PWR1 = 1; // chan1_power_on
    localparam int DDAC_BIT_PWR0 = 0; // chan0_power_on

    // ----------------------------------------
    // Code layout
    // ----------------------------------------
    localparam int DDAC_CODE_W = 12; // Converter code width
    localparam int DDAC_HIGH_NIB = 4; // Used bits of a high data byte

endpackage

// ---- design/ddac_chan_if.sv ----
// Interface between the register file and one channel code latch.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ddac_chan_if;
    logic [7:0] low; // Current low data byte
    logic [7:0] high; // Current high data byte
    logic mode8; // 8-bit mode
    logic zero_force_n; // 0 forces the output code to zero
    logic load; // One-cycle pulse: move data into the latch
    logic [11:0] code; // Code presented to the converter

    // Register file side
    modport ctrl (
        output low,
        output high,
        output mode8,
        output zero_force_n,
        output load,
        input code
    );

    // Latch side
    modport chan (
        input low,
        input high,
        input mode8,
        input zero_force_n,
        input load,
        output code
    );
endinterface

// ---- design/ddac_chan.sv ----
// One channel code latch with the zero-force gate in front of it.
// Assumes load is a registered one-cycle pulse from the register file.
`timescale 1ns/1ps
module ddac_chan
    import ddac_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    ddac_chan_if.chan ch
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [DDAC_CODE_W-1:0] held; // Latched code, kept through power-down
        logic [DDAC_CODE_W-1:0] out; // Gated code to the converter
    } ddac_chan_st_t;

    ddac_chan_st_t st_reg; // Registered state
    ddac_chan_st_t st_next; // Next state

    // Next state
    always_comb begin
        st_next = st_reg;
        if (ch.load) begin
            // 8-bit mode puts the low byte at the top of the code
            if (ch.mode8) begin
                st_next.held = {ch.low, {DDAC_HIGH_NIB{1'b0}}}; // R1
            end else begin
                st_next.held = {ch.high[DDAC_HIGH_NIB-1:0], ch.low}; // R4
            end
        end
        // Forcing zero only gates the output; the latch keeps its code
        st_next.out = ch.zero_force_n ? st_next.held : '0; // R17
    end

    // Register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ch.code = st_reg.out;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_load_layout: assert property ( // R4
        @(posedge clk) disable iff (sys_rst)
        (ch.load && !ch.mode8) |=> st_reg.held == {$past(ch.high[3:0]), $past(ch.low)})
        else $error("12-bit code not right-justified");

    chk_load_eight: assert property ( // R1
        @(posedge clk) disable iff (sys_rst)
        (ch.load && ch.mode8) |=> st_reg.held == {$past(ch.low), 4'h0})
        else $error("8-bit code not placed in upper bits");

    chk_hold_no_load: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        !ch.load |=> st_reg.held == $past(st_reg.held))
        else $error("latched code changed without a load");

    chk_zero_force: assert property ( // R8
        @(posedge clk) disable iff (sys_rst)
        !ch.zero_force_n |=> ch.code == 12'h000)
        else $error("zero force did not clear output code");

endmodule

// ---- design/ddac_ctrl.sv ----
// Dual converter control registers on the special-function-register bus.
// Assumes the bus strobes are single-cycle and synchronous to clk.
//
// Function
// R1 - Bit 7 high selects 8-bit mode
// R2 - 12-bit: only low-byte write updates output
// R3 - Software writes high byte before low byte
// R4 - Code right-justified: low byte, high nibble
// R5 - Bit 6 selects channel 1 span
// R6 - Bit 5 selects channel 0 span
// R7 - Bit 4 low forces channel 1 zero
// R8 - Bit 3 low forces channel 0 zero
// R9 - Async mode: low write updates channel
// R10 - Sync mode holds; setting bit updates both
// R11 - Bit 1 powers channel 1
// R12 - Bit 0 powers channel 0
// R13 - Data registers clear to zero at reset
// R14 - Enabled channels take analog inputs four, five
// R15 - Reference span needs the ADC powered (not modelled: span bits pass straight through)
// R16 - Outputs high-impedance until software enables
// R17 - Power-down and zero keep the data
`timescale 1ns/1ps
module ddac_ctrl
    import ddac_pkg::*;
#(
    parameter int NUM_CHAN = 2 // Channels served
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic [11:0] chan0_code,
    output logic [11:0] chan1_code,
    output logic chan0_span_select,
    output logic chan1_span_select,
    output logic chan0_drive_en,
    output logic chan1_drive_en,
    output logic analog_input_four_free,
    output logic analog_input_five_free
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] ctrl; // converter_control
        logic [NUM_CHAN-1:0][7:0] low; // chanN_code_low
        logic [NUM_CHAN-1:0][7:0] high; // chanN_code_high
        logic [NUM_CHAN-1:0] load; // Load pulse per channel
        logic [7:0] rdata; // Read data held for the bus
        logic [NUM_CHAN-1:0] pin_free; // Analog input pin still free
    } ddac_ctrl_st_t;

    ddac_ctrl_st_t st_reg; // Registered state
    ddac_ctrl_st_t st_next; // Next state

    // Address decodes
    logic [NUM_CHAN-1:0] hit_low; // Write to a low data byte
    logic [NUM_CHAN-1:0] hit_high; // Write to a high data byte
    logic hit_ctrl; // Write to converter_control
    logic sync_rise; // Update bit goes from 0 to 1

    // ----------------------------------------
    // Decode and next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        hit_low[0] = sfr_wr && (sfr_addr == DDAC_ADDR_C0_LOW);
        hit_low[1] = sfr_wr && (sfr_addr == DDAC_ADDR_C1_LOW);
        hit_high[0] = sfr_wr && (sfr_addr == DDAC_ADDR_C0_HIGH);
        hit_high[1] = sfr_wr && (sfr_addr == DDAC_ADDR_C1_HIGH);
        hit_ctrl = sfr_wr && (sfr_addr == DDAC_ADDR_CTRL);
        // Releasing a synchronous hold moves both channels together
        sync_rise = hit_ctrl && sfr_wdata[DDAC_BIT_ASYNC] && !st_reg.ctrl[DDAC_BIT_ASYNC]; // R10

        // Control register
        if (hit_ctrl) begin
            st_next.ctrl = sfr_wdata; // R5
        end

        // Data registers and load pulses
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (hit_low[i]) begin
                st_next.low[i] = sfr_wdata;
            end
            if (hit_high[i]) begin
                st_next.high[i] = sfr_wdata;
            end
            // Of the data bytes only a low-byte write loads; a lone high byte waits for it
            st_next.load[i] = (hit_low[i] && st_reg.ctrl[DDAC_BIT_ASYNC]) || sync_rise; // R2 R9
        end

        // Registered read answer; unmapped addresses read zero
        if (sfr_rd) begin
            unique case (sfr_addr)
                DDAC_ADDR_C0_LOW: st_next.rdata = st_reg.low[0];
                DDAC_ADDR_C0_HIGH: st_next.rdata = st_reg.high[0];
                DDAC_ADDR_C1_LOW: st_next.rdata = st_reg.low[1];
                DDAC_ADDR_C1_HIGH: st_next.rdata = st_reg.high[1];
                DDAC_ADDR_CTRL: st_next.rdata = st_reg.ctrl;
                default: st_next.rdata = 8'h00;
            endcase
        end

        // A powered channel takes over its shared analog input pin
        st_next.pin_free[0] = !st_next.ctrl[DDAC_BIT_PWR0]; // R14
        st_next.pin_free[1] = !st_next.ctrl[DDAC_BIT_PWR1]; // R14
    end

    // ----------------------------------------
    // Register; everything starts disabled and cleared
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg.ctrl <= DDAC_RST_CTRL; // R16
            st_reg.low <= {NUM_CHAN{DDAC_RST_CODE}}; // R13
            st_reg.high <= {NUM_CHAN{DDAC_RST_CODE}}; // R13
            st_reg.load <= '0;
            st_reg.rdata <= 8'h00;
            st_reg.pin_free <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Channel latches
    // ----------------------------------------
    ddac_chan_if c_if[NUM_CHAN] ();

    // Zero-force bits sit at different positions per channel
    localparam int ZFN_POS[2] = '{DDAC_BIT_ZFN0, DDAC_BIT_ZFN1};

    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
        assign c_if[g].low = st_reg.low[g];
        assign c_if[g].high = st_reg.high[g];
        assign c_if[g].mode8 = st_reg.ctrl[DDAC_BIT_MODE8]; // R1
        assign c_if[g].zero_force_n = st_reg.ctrl[ZFN_POS[g]]; // R7 R8
        assign c_if[g].load = st_reg.load[g];
        ddac_chan u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .ch(c_if[g])
        );
    end

    // ----------------------------------------
    // Outputs, all from flip-flops
    // ----------------------------------------
    assign sfr_rdata = st_reg.rdata;
    assign chan0_code = c_if[0].code;
    assign chan1_code = c_if[1].code;
    assign chan0_span_select = st_reg.ctrl[DDAC_BIT_SPAN0]; // R6
    assign chan1_span_select = st_reg.ctrl[DDAC_BIT_SPAN1]; // R5
    // Off channel leaves its pin high-impedance, not driven low
    assign chan0_drive_en = st_reg.ctrl[DDAC_BIT_PWR0]; // R12
    assign chan1_drive_en = st_reg.ctrl[DDAC_BIT_PWR1]; // R11
    assign analog_input_four_free = st_reg.pin_free[0];
    assign analog_input_five_free = st_reg.pin_free[1];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_async_low_load: assert property ( // R9
        @(posedge clk) disable iff (sys_rst)
        (sfr_wr && sfr_addr == DDAC_ADDR_C1_LOW && st_reg.ctrl[DDAC_BIT_ASYNC])
        |=> st_reg.load[1] ##1 chan1_code == ($past(st_reg.ctrl[DDAC_BIT_ZFN1])
            ? ($past(st_reg.ctrl[DDAC_BIT_MODE8]) ? {$past(st_reg.low[1]), 4'h0}
               : {$past(st_reg.high[1][3:0]), $past(st_reg.low[1])}) : 12'h000))
        else $error("async low write did not update channel 1");

    chk_high_no_load: assert property ( // R2
        @(posedge clk) disable iff (sys_rst)
        (sfr_wr && sfr_addr == DDAC_ADDR_C0_HIGH) |=> !st_reg.load[0])
        else $error("high byte write loaded channel 0");

    chk_sync_hold: assert property ( // R10
        @(posedge clk) disable iff (sys_rst)
        // A control write just before may still be moving the gated code
        (sfr_wr && sfr_addr == DDAC_ADDR_C0_LOW && !st_reg.ctrl[DDAC_BIT_ASYNC]
         && $stable(st_reg.ctrl))
        |=> !st_reg.load[0] ##1 chan0_code == $past(chan0_code, 2))
        else $error("synchronous mode let a low write through");

    chk_sync_release: assert property ( // R10
        @(posedge clk) disable iff (sys_rst)
        (sfr_wr && sfr_addr == DDAC_ADDR_CTRL && !st_reg.ctrl[DDAC_BIT_ASYNC]
         && sfr_wdata[DDAC_BIT_ASYNC]) |=> (st_reg.load == 2'b11))
        else $error("setting update bit did not load both channels");

    chk_reset_state: assert property ( // R13
        @(posedge clk)
        $past(sys_rst) |-> (st_reg.low == '0 && st_reg.high == '0
            && !chan0_drive_en && !chan1_drive_en && chan0_code == 12'h000
            && chan1_code == 12'h000))
        else $error("reset left data or outputs active");

    chk_span_source: assert property ( // R6
        @(posedge clk) disable iff (sys_rst)
        $changed(chan0_span_select) |-> $past(hit_ctrl)
            && chan0_span_select == $past(sfr_wdata[DDAC_BIT_SPAN0]))
        else $error("channel 0 span changed without control write");

    chk_span1_source: assert property ( // R5
        @(posedge clk) disable iff (sys_rst)
        $changed(chan1_span_select) |-> $past(hit_ctrl)
            && chan1_span_select == $past(sfr_wdata[DDAC_BIT_SPAN1]))
        else $error("channel 1 span changed without control write");

    chk_power_pin: assert property ( // R14
        @(posedge clk) disable iff (sys_rst)
        (analog_input_four_free != chan0_drive_en)
            && (analog_input_five_free != chan1_drive_en))
        else $error("pin sharing disagrees with power state");

    chk_power_write: assert property ( // R11
        @(posedge clk) disable iff (sys_rst)
        hit_ctrl |=> (chan1_drive_en == $past(sfr_wdata[DDAC_BIT_PWR1]))
            && (chan0_drive_en == $past(sfr_wdata[DDAC_BIT_PWR0])))
        else $error("power bits not applied");

endmodule

// ---- test/ddac_cpu_model.sv ----
// Bus-master model of the core that writes the converter registers.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module ddac_cpu_model (
    input wire logic clk,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic sfr_wr,
    output logic sfr_rd
);
    // Idle bus at time zero
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    end

    // One strobe across one taking edge; the released bus shows inverted
    // values so that a stale address never looks valid
    task automatic strobe(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = wr;
        sfr_rd = ~wr;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        strobe(a, d, 1'b1);
    endtask

    task automatic read_reg(input logic [7:0] a);
        strobe(a, 8'h00, 1'b0);
    endtask
endmodule

// ---- test/dual_dac_control_regs_bench.sv ----
// Self-checking bench for the converter control registers.
// Assumes ddac_ctrl and the core model; one 50 MHz clock.
`timescale 1ns/1ps
module dual_dac_control_regs_bench;
    import ddac_pkg::*;
    logic clk;
    logic sys_rst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_rdata;
    logic [29:0] outs; // Packed view of all converter-side outputs
    logic [7:0] regs [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04}; // Register mirror
    logic [11:0] lat [2] = '{12'h000, 12'h000}; // Expected latched codes
    logic [7:0] rd_q [$]; // Expected read answers
    logic [29:0] out_q [$]; // Expected output snapshots
    logic rd_pend = 1'b0;
    logic out_req = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    ddac_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd));
    ddac_ctrl #(.NUM_CHAN(2)) dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .chan0_code(outs[29:18]), .chan1_code(outs[17:6]),
        .chan0_span_select(outs[5]), .chan1_span_select(outs[4]),
        .chan0_drive_en(outs[3]), .chan1_drive_en(outs[2]),
        .analog_input_four_free(outs[1]), .analog_input_five_free(outs[0]));

    // 20 ns clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Code a channel would latch now; 8-bit mode puts low in the top bits
    function automatic logic [11:0] code_of(input int ch);
        return regs[4][7] ? {regs[2*ch], 4'h0} : {regs[2*ch+1][3:0], regs[2*ch]};
    endfunction

    task automatic complete_run();
        // A note never compared means a result never appeared
        if (rd_q.size() != 0 || out_q.size() != 0)
            num_errors++;
        $display("errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read answers
    task automatic cmp_rd(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: read expected %h got %h", $time, exp, got);
        end
    endtask

    // Converter-side output snapshots
    task automatic cmp_out(input logic [29:0] exp, input logic [29:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: outputs expected %h got %h", $time, exp, got);
        end
    endtask

    // Write and mirror: low write loads in async mode, 0->1 on bit 2 loads both
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        logic was_async;
        was_async = regs[4][2];
        regs[a - 8'hf9] = d;
        if (a == 8'hfd && !was_async && d[2]) begin
            lat[0] = code_of(0);
            lat[1] = code_of(1);
        end
        if ((a == 8'hf9 || a == 8'hfb) && was_async)
            lat[a == 8'hfb] = code_of(a == 8'hfb);
        cpu.write_reg(a, d);
    endtask

    // Read with its expected answer noted; unmapped places answer zero
    task automatic br(input logic [7:0] a);
        rd_q.push_back((a >= 8'hf9 && a <= 8'hfd) ? regs[a - 8'hf9] : 8'h00);
        cpu.read_reg(a);
    endtask

    // Note expected outputs once the two-edge load path has settled
    task automatic chk();
        logic [7:0] c;
        c = regs[4];
        repeat (2) @(posedge clk);
        #1;
        out_q.push_back({c[3] ? lat[0] : 12'h000, c[4] ? lat[1] : 12'h000,
            c[5], c[6], c[0], c[1], ~c[0], ~c[1]});
        out_req = 1'b1;
        @(posedge clk);
        #1;
        out_req = 1'b0;
    endtask

    // Watcher: takes the oldest note whenever a result is due
    always @(posedge clk) begin
        if (rd_pend && rd_q.size() > 0)
            cmp_rd(rd_q.pop_front(), sfr_rdata);
        if (out_req && out_q.size() > 0)
            cmp_out(out_q.pop_front(), outs);
        rd_pend = sfr_rd;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'ha98b7fe4));
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        for (int a = 248; a <= 254; a++) br(8'(a));
        chk();
        for (int i = 0; i < 8; i++) begin
            bw(8'hfd, {1'b0, 4'($urandom), 1'b1, 2'($urandom)});
            for (int c = 0; c < 2; c++) begin
                bw(8'hfa + 8'(2 * c), 8'($urandom));
                chk();
                bw(8'hf9 + 8'(2 * c), 8'($urandom));
                chk();
            end
        end
        bw(8'hfd, 8'h1b);
        // High byte before low byte of each channel: fa, f9, fc, fb
        for (int c = 0; c < 4; c++) bw(8'hf9 + 8'(c ^ 1), 8'($urandom));
        chk();
        bw(8'hfd, 8'h1f);
        chk();
        bw(8'hf9, 8'($urandom));
        bw(8'hfb, 8'($urandom));
        bw(8'hfd, 8'h9f);
        bw(8'hf9, 8'($urandom));
        bw(8'hfb, 8'($urandom));
        chk();
        bw(8'hfd, 8'h87);
        chk();
        bw(8'hfd, 8'h84);
        chk();
        bw(8'hfd, 8'h9f);
        chk();
        for (int a = 249; a <= 253; a++) br(8'(a));
        // Reset in mid-run with live data must clear everything again
        @(posedge clk);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        regs = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
        lat = '{12'h000, 12'h000};
        for (int a = 249; a <= 253; a++) br(8'(a));
        chk();
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule
